// ### inc/i2c_cmd_defs.svh
// Constants for the two-wire command engine: bus timing, control byte and text fields.
`ifndef I2C_CMD_DEFS_SVH
`define I2C_CMD_DEFS_SVH

`define CLK_PERIOD_NS    25
`define QUARTER_NS       2500
`define QUARTER_CYCLES   ((`QUARTER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define DIR_BIT          0
`define RD_DIR           1'b1
`define WR_DIR           1'b0
`define ACK_BIT          4'h8
`define PH_SAMPLE        2'h2
`define PH_LAST          2'h3
`define DEC_DIGITS       5
`define HEX_DIGITS       4
`define BIN_DIGITS       16
`define BCD_WIDTH        20
`define ASCII_ZERO       8'h30
`define ASCII_ALPHA      8'h37
`define ARRAY_LEN_DEF    16

`endif

// ### inc/i2c_cmd_pkg.sv
// Types shared by the two-wire command engine and its users.
`default_nettype none
package i2c_cmd_pkg;
  typedef enum logic [1:0] {ADDR_NONE, ADDR_8, ADDR_16} addr_mode_t;
  typedef enum logic [1:0] {RX_BYTES, RX_WORDS, RX_ARRAY} rx_kind_t;
  typedef enum logic [2:0] {TX_BYTE, TX_WORD, TX_REPEAT, TX_DEC, TX_HEX, TX_BIN} tx_kind_t;
  typedef enum logic [2:0] {B_IDLE, B_START, B_LOAD, B_BIT, B_STOP} bus_state_t;
  typedef enum logic [2:0] {ST_CTRL1, ST_ADHI, ST_ADLO, ST_CTRL2, ST_RX, ST_TX} stage_t;

  typedef struct packed {
    logic        read;
    logic [7:0]  control;
    addr_mode_t  addr_mode;
    logic [15:0] addr;
    rx_kind_t    rx_kind;
    logic        use_count;
    logic [7:0]  count;
  } cmd_t;

  typedef struct packed {
    tx_kind_t    kind;
    logic [15:0] value;
    logic [7:0]  count;
    logic        last;
  } tx_item_t;
endpackage
`default_nettype wire

// ### hw/i2c_master_cmd.sv
// Two-wire bus master that runs one whole read or write transaction per command.
// How it works
// R01 - First byte is control: upper seven bits target code and address, bit 0 direction.
// R02 - Read commands force the control direction bit to one.
// R03 - Write commands force the control direction bit to zero.
// R04 - Address phase optional, one or two bytes; issuer picks what the target expects.
// R05 - Items move at declared width: byte one, word two bytes, high byte first.
// R06 - Array reads fill consecutive elements, stopping at count or at array length.
// R07 - Writes send control, then address bytes, then data items in list order.
// R08 - After read both lines released; after write clock stays flagged as output.
// R09 - Lines only pulled low or released, never driven high.
// R10 - Write items: raw bytes or words, repeated, or decimal, hex, binary text, mixed freely.
// R11 - Addressed read: write-direction control and address, repeated start, read control.
// R12 - Master acks received bytes except last; slave must ack every written byte.
`default_nettype none
`include "i2c_cmd_defs.svh"
module i2c_master_cmd #(
  parameter int ARRAY_LEN = `ARRAY_LEN_DEF,
  parameter int QUARTER   = `QUARTER_CYCLES
) (
  // Clock and reset
  input  wire logic                 MCLK,
  input  wire logic                 RESETN,
  // Command
  input  wire logic                 CMD_VALID,
  output logic                      CMD_READY,
  input  wire i2c_cmd_pkg::cmd_t    CMD,
  // Write items
  input  wire logic                 TX_VALID,
  output logic                      TX_READY,
  input  wire i2c_cmd_pkg::tx_item_t TX_ITEM,
  // Received bytes
  output logic                      RX_VALID,
  input  wire logic                 RX_READY,
  output logic [7:0]                RX_DATA,
  output logic [8:0]                RX_INDEX,
  output logic                      RX_LAST,
  // Status
  output logic                      BUSY,
  output logic                      DONE,
  output logic                      NACK_ERR,
  output logic                      SCL_HELD,
  // Bus pins
  input  wire logic                 SDA_IN,
  output logic                      SDA_OUT,
  output logic                      SDA_OE,
  input  wire logic                 SCL_IN,
  output logic                      SCL_OUT,
  output logic                      SCL_OE
);

  logic                    sda_m, sda_s, scl_m, scl_s;
  i2c_cmd_pkg::tx_item_t   buf_q [2];
  logic                    wr_ptr_q, rd_ptr_q;
  logic [1:0]              cnt_q, cnt_d;
  logic                    tx_ready_q, push, pop;
  i2c_cmd_pkg::bus_state_t st_q;
  i2c_cmd_pkg::stage_t     stage_q;
  i2c_cmd_pkg::cmd_t       cmd_q;
  i2c_cmd_pkg::tx_item_t   item_q;
  logic [15:0]             qcnt_q;
  logic [1:0]              ph_q;
  logic [3:0]              bit_q;
  logic [7:0]              sh_q;
  logic                    have_q, nack_q;
  logic [8:0]              idx_q, rx_left_q, rx_idx_q;
  logic                    timed, tick, adv, receiving, byte_done, stop_done;
  logic                    sda_oe_d, scl_oe_d, sda_oe_q, scl_oe_q;
  logic                    rx_valid_q, rx_last_q, done_q, busy_q, ready_q, held_q;
  logic [7:0]              rx_data_q;
  logic [8:0]              rx_index_q;

  function automatic logic [19:0] to_bcd(input logic [15:0] v);
    logic [35:0] s;
    s = {20'h0, v};
    for (int i = 0; i < 16; i++) begin
      for (int j = 0; j < `DEC_DIGITS; j++) begin
        if (s[16+4*j +: 4] > 4'h4) s[16+4*j +: 4] = s[16+4*j +: 4] + 4'h3;
      end
      s = {s[34:0], 1'b0};
    end
    return s[35:16];
  endfunction

  function automatic logic [7:0] digit_char(input logic [3:0] d);
    return (d < 4'ha) ? `ASCII_ZERO + {4'h0, d} : `ASCII_ALPHA + {4'h0, d};
  endfunction

  function automatic logic [8:0] item_len(input i2c_cmd_pkg::tx_item_t it);
    case (it.kind)
      i2c_cmd_pkg::TX_WORD:   return 9'h2;
      i2c_cmd_pkg::TX_REPEAT: return {1'b0, it.count};
      i2c_cmd_pkg::TX_DEC:    return 9'(`DEC_DIGITS);
      i2c_cmd_pkg::TX_HEX:    return 9'(`HEX_DIGITS);
      i2c_cmd_pkg::TX_BIN:    return 9'(`BIN_DIGITS);
      default:                return 9'h1;
    endcase
  endfunction

  // Text is produced most significant digit first, with leading zeros kept.
  function automatic logic [7:0] item_byte(input i2c_cmd_pkg::tx_item_t it,
                                           input logic [8:0] idx);
    logic [19:0] bcd;
    logic [2:0]  rev;
    bcd = to_bcd(it.value);
    rev = 3'h0;
    case (it.kind)
      i2c_cmd_pkg::TX_WORD: return (idx == 9'h0) ? it.value[15:8] : it.value[7:0];
      i2c_cmd_pkg::TX_DEC: begin
        rev = 3'(`DEC_DIGITS - 1) - idx[2:0];
        return digit_char(4'(bcd >> {rev, 2'b00}));
      end
      i2c_cmd_pkg::TX_HEX: begin
        rev = 3'(`HEX_DIGITS - 1) - idx[2:0];
        return digit_char(4'(it.value >> {rev, 2'b00}));
      end
      i2c_cmd_pkg::TX_BIN:
        return `ASCII_ZERO | {7'h0, it.value[4'(`BIN_DIGITS - 1) - idx[3:0]]};
      default: return it.value[7:0];
    endcase
  endfunction

  function automatic logic [8:0] rx_total(input i2c_cmd_pkg::cmd_t c);
    case (c.rx_kind)
      i2c_cmd_pkg::RX_BYTES: return {1'b0, c.count};
      i2c_cmd_pkg::RX_WORDS: return {c.count, 1'b0};
      default:               return c.use_count ? {1'b0, c.count} : 9'(ARRAY_LEN);
    endcase
  endfunction

  // Pin synchronisers.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      scl_m <= 1'b1;
      scl_s <= 1'b1;
    end else begin
      sda_m <= SDA_IN;
      sda_s <= sda_m;
      scl_m <= SCL_IN;
      scl_s <= scl_m;
    end
  end

  // Two-entry item buffer; an empty buffer stalls the bus with the clock held low.
  assign push  = TX_VALID && tx_ready_q;
  assign pop   = (st_q == i2c_cmd_pkg::B_LOAD) && (stage_q == i2c_cmd_pkg::ST_TX) &&
                 !have_q && (cnt_q != 2'h0);
  assign cnt_d = cnt_q + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      buf_q[0]   <= '0;
      buf_q[1]   <= '0;
      wr_ptr_q   <= 1'b0;
      rd_ptr_q   <= 1'b0;
      cnt_q      <= 2'h0;
      tx_ready_q <= 1'b0;
    end else begin
      if (push) buf_q[wr_ptr_q] <= TX_ITEM;
      if (push) wr_ptr_q <= !wr_ptr_q;
      if (pop) rd_ptr_q <= !rd_ptr_q;
      cnt_q      <= cnt_d;
      tx_ready_q <= (cnt_d != 2'h2);
    end
  end

  // Quarter-bit timing; a released clock line is waited on so slaves may stretch it.
  assign timed = (st_q == i2c_cmd_pkg::B_START) || (st_q == i2c_cmd_pkg::B_BIT) ||
                 (st_q == i2c_cmd_pkg::B_STOP);
  assign tick  = (qcnt_q == 16'(QUARTER - 1));
  assign adv   = timed && tick && (scl_s || scl_oe_q);
  assign receiving = (stage_q == i2c_cmd_pkg::ST_RX);
  assign byte_done = (st_q == i2c_cmd_pkg::B_BIT) && adv && (ph_q == `PH_LAST) &&
                     (bit_q == `ACK_BIT);
  assign stop_done = (st_q == i2c_cmd_pkg::B_STOP) && adv && (ph_q == `PH_LAST);

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      qcnt_q <= 16'h0;
      ph_q   <= 2'h0;
    end else begin
      if (!timed || adv) qcnt_q <= 16'h0;
      else if (!tick) qcnt_q <= qcnt_q + 16'h1;
      if (adv) ph_q <= ph_q + 2'h1;
    end
  end

  // Transaction sequencer.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      st_q      <= i2c_cmd_pkg::B_IDLE;
      stage_q   <= i2c_cmd_pkg::ST_CTRL1;
      cmd_q     <= '0;
      item_q    <= '0;
      bit_q     <= 4'h0;
      sh_q      <= 8'h0;
      have_q    <= 1'b0;
      nack_q    <= 1'b0;
      idx_q     <= 9'h0;
      rx_left_q <= 9'h0;
      rx_idx_q  <= 9'h0;
    end else begin
      case (st_q)
        i2c_cmd_pkg::B_IDLE: if (CMD_VALID && ready_q) begin
          cmd_q     <= CMD;
          nack_q    <= 1'b0;
          have_q    <= 1'b0;
          rx_idx_q  <= 9'h0;
          rx_left_q <= rx_total(CMD); // R06
          stage_q   <= (CMD.read && CMD.addr_mode == i2c_cmd_pkg::ADDR_NONE) ?
                       i2c_cmd_pkg::ST_CTRL2 : i2c_cmd_pkg::ST_CTRL1; // R11
          st_q      <= i2c_cmd_pkg::B_START;
        end
        i2c_cmd_pkg::B_START: if (adv && ph_q == `PH_LAST) st_q <= i2c_cmd_pkg::B_LOAD;
        i2c_cmd_pkg::B_LOAD: begin
          bit_q <= 4'h0;
          case (stage_q)
            i2c_cmd_pkg::ST_CTRL1: begin
              sh_q <= {cmd_q.control[7:1], `WR_DIR}; // R01 R03 R11
              st_q <= i2c_cmd_pkg::B_BIT;
            end
            i2c_cmd_pkg::ST_CTRL2: begin
              sh_q <= {cmd_q.control[7:1], `RD_DIR}; // R01 R02
              st_q <= i2c_cmd_pkg::B_BIT;
            end
            i2c_cmd_pkg::ST_ADHI: begin
              sh_q <= cmd_q.addr[15:8]; // R04
              st_q <= i2c_cmd_pkg::B_BIT;
            end
            i2c_cmd_pkg::ST_ADLO: begin
              sh_q <= cmd_q.addr[7:0]; // R04
              st_q <= i2c_cmd_pkg::B_BIT;
            end
            i2c_cmd_pkg::ST_RX: if (!rx_valid_q) st_q <= i2c_cmd_pkg::B_BIT;
            i2c_cmd_pkg::ST_TX: begin
              if (!have_q) begin
                if (pop) begin
                  item_q <= buf_q[rd_ptr_q];
                  have_q <= 1'b1;
                  idx_q  <= 9'h0;
                end
              end else if (idx_q == item_len(item_q)) begin // R05
                have_q <= 1'b0;
                if (item_q.last) st_q <= i2c_cmd_pkg::B_STOP;
              end else begin
                sh_q  <= item_byte(item_q, idx_q); // R10
                idx_q <= idx_q + 9'h1;
                st_q  <= i2c_cmd_pkg::B_BIT;
              end
            end
            default: st_q <= i2c_cmd_pkg::B_STOP;
          endcase
        end
        i2c_cmd_pkg::B_BIT: if (adv) begin
          if (ph_q == `PH_SAMPLE) begin
            if (receiving && bit_q < `ACK_BIT) sh_q <= {sh_q[6:0], sda_s};
            if (!receiving && bit_q == `ACK_BIT && sda_s) nack_q <= 1'b1; // R12
          end
          if (ph_q == `PH_LAST) begin
            if (!receiving) sh_q <= {sh_q[6:0], 1'b0};
            bit_q <= bit_q + 4'h1;
            if (bit_q == `ACK_BIT) begin
              st_q <= i2c_cmd_pkg::B_LOAD;
              if (nack_q) st_q <= i2c_cmd_pkg::B_STOP; // R12
              else begin
                case (stage_q)
                  i2c_cmd_pkg::ST_CTRL1: // R07
                    stage_q <= (cmd_q.addr_mode == i2c_cmd_pkg::ADDR_16) ? i2c_cmd_pkg::ST_ADHI :
                               (cmd_q.addr_mode == i2c_cmd_pkg::ADDR_8) ? i2c_cmd_pkg::ST_ADLO :
                               i2c_cmd_pkg::ST_TX;
                  i2c_cmd_pkg::ST_ADHI: stage_q <= i2c_cmd_pkg::ST_ADLO;
                  i2c_cmd_pkg::ST_ADLO: begin
                    stage_q <= cmd_q.read ? i2c_cmd_pkg::ST_CTRL2 : i2c_cmd_pkg::ST_TX;
                    if (cmd_q.read) st_q <= i2c_cmd_pkg::B_START; // R11
                  end
                  i2c_cmd_pkg::ST_CTRL2: begin
                    stage_q <= i2c_cmd_pkg::ST_RX;
                    if (rx_left_q == 9'h0) st_q <= i2c_cmd_pkg::B_STOP;
                  end
                  i2c_cmd_pkg::ST_RX: begin
                    rx_left_q <= rx_left_q - 9'h1;
                    rx_idx_q  <= rx_idx_q + 9'h1; // R06
                    if (rx_left_q == 9'h1) st_q <= i2c_cmd_pkg::B_STOP;
                  end
                  default: stage_q <= i2c_cmd_pkg::ST_TX;
                endcase
              end
            end
          end
        end
        i2c_cmd_pkg::B_STOP: if (stop_done) st_q <= i2c_cmd_pkg::B_IDLE;
        default: st_q <= i2c_cmd_pkg::B_IDLE;
      endcase
    end
  end

  // Line drive per phase; an enable only ever pulls the line low.
  always_comb begin
    sda_oe_d = 1'b0;
    scl_oe_d = 1'b0;
    case (st_q)
      i2c_cmd_pkg::B_START: begin
        sda_oe_d = ph_q[1];
        // A repeated start pulls the clock low first, so the data line can rise under a low clock.
        scl_oe_d = (ph_q == `PH_LAST) ||
                   ((ph_q == 2'h0) && (stage_q == i2c_cmd_pkg::ST_CTRL2) &&
                    (cmd_q.addr_mode != i2c_cmd_pkg::ADDR_NONE)); // R11
      end
      i2c_cmd_pkg::B_LOAD: scl_oe_d = 1'b1;
      i2c_cmd_pkg::B_BIT: begin
        scl_oe_d = !ph_q[1];
        if (bit_q < `ACK_BIT) sda_oe_d = !receiving && !sh_q[7];
        else sda_oe_d = receiving && (rx_left_q != 9'h1); // R12
      end
      i2c_cmd_pkg::B_STOP: begin
        scl_oe_d = (ph_q == 2'h0);
        sda_oe_d = (ph_q != `PH_LAST);
      end
      default: ;
    endcase
  end

  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      sda_oe_q <= 1'b0;
      scl_oe_q <= 1'b0;
    end else begin
      // Data waits one cycle after the clock falls, so it moves while the clock is high only to form a start or a stop.
      sda_oe_q <= (scl_oe_d && !scl_oe_q) ? sda_oe_q : sda_oe_d; // R09
      scl_oe_q <= scl_oe_d; // R09
    end
  end

  // Received byte holding register; the bus waits with the clock low until it drains.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rx_valid_q <= 1'b0;
      rx_data_q  <= 8'h0;
      rx_index_q <= 9'h0;
      rx_last_q  <= 1'b0;
    end else begin
      if (rx_valid_q && RX_READY) rx_valid_q <= 1'b0;
      if (byte_done && receiving && !nack_q) begin
        rx_valid_q <= 1'b1;
        rx_data_q  <= sh_q;
        rx_index_q <= rx_idx_q; // R06
        rx_last_q  <= (rx_left_q == 9'h1);
      end
    end
  end

  // Status.
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      done_q  <= 1'b0;
      busy_q  <= 1'b0;
      ready_q <= 1'b0;
      held_q  <= 1'b0;
    end else begin
      done_q  <= stop_done;
      busy_q  <= ((st_q != i2c_cmd_pkg::B_IDLE) && !stop_done) || (CMD_VALID && ready_q);
      ready_q <= ((st_q == i2c_cmd_pkg::B_IDLE) && !(CMD_VALID && ready_q)) || stop_done;
      if (CMD_VALID && ready_q) held_q <= 1'b0;
      else if (stop_done) held_q <= !cmd_q.read; // R08
    end
  end

  assign CMD_READY = ready_q;
  assign TX_READY  = tx_ready_q;
  assign RX_VALID  = rx_valid_q;
  assign RX_DATA   = rx_data_q;
  assign RX_INDEX  = rx_index_q;
  assign RX_LAST   = rx_last_q;
  assign BUSY      = busy_q;
  assign DONE      = done_q;
  assign NACK_ERR  = nack_q;
  assign SCL_HELD  = held_q;
  assign SDA_OE    = sda_oe_q;
  assign SCL_OE    = scl_oe_q;
  assign SDA_OUT   = 1'b0; // R09
  assign SCL_OUT   = 1'b0; // R09

endmodule
`default_nettype wire

// ### bench/i2c_master_cmd_checker.sv
// Concurrent checks on the ports of the two-wire command engine.
`default_nettype none
module i2c_master_cmd_checker (
  // Clock and reset
  input wire logic              MCLK,
  input wire logic              RESETN,
  // Command and status
  input wire logic              CMD_VALID,
  input wire logic              CMD_READY,
  input wire i2c_cmd_pkg::cmd_t CMD,
  input wire logic              BUSY,
  input wire logic              DONE,
  input wire logic              SCL_HELD,
  // Received bytes
  input wire logic              RX_VALID,
  input wire logic              RX_READY,
  input wire logic [7:0]        RX_DATA,
  input wire logic [8:0]        RX_INDEX,
  // Bus pins
  input wire logic              SDA_OUT,
  input wire logic              SCL_OUT,
  input wire logic              SDA_OE
);
  default clocking @(posedge MCLK); endclocking
  default disable iff (!RESETN);
  logic rd_q;
  always_ff @(posedge MCLK or negedge RESETN) begin
    if (!RESETN) begin
      rd_q <= 1'b0;
    end else if (CMD_VALID && CMD_READY) begin
      rd_q <= CMD.read;
    end
  end
  a_pins_never_high: assert property (!SDA_OUT && !SCL_OUT)
    else $error("bus pin driven high");
  a_accept_starts_busy: assert property (CMD_VALID && CMD_READY |=> BUSY && !CMD_READY)
    else $error("accept did not start a transaction");
  a_done_one_cycle: assert property (DONE |=> !DONE)
    else $error("done longer than one cycle");
  a_done_frees_port: assert property (DONE |-> CMD_READY && !BUSY)
    else $error("done without free command port");
  a_busy_not_ready: assert property (BUSY |-> !CMD_READY)
    else $error("ready while busy");
  a_rx_holds_byte: assert property (RX_VALID && !RX_READY |=> RX_VALID && $stable(RX_DATA)
    && $stable(RX_INDEX)) else $error("received byte changed before taken");
  a_rx_consumed: assert property (RX_VALID && RX_READY |=> !RX_VALID)
    else $error("received byte not withdrawn");
  a_idle_data_free: assert property (CMD_READY && !DONE |-> !SDA_OE)
    else $error("data line held while idle");
  a_clock_flag_dir: assert property (DONE && !CMD_VALID |=> SCL_HELD == !rd_q)
    else $error("clock flag wrong for direction");
endmodule
bind i2c_master_cmd i2c_master_cmd_checker u_chk (
  .MCLK(MCLK), .RESETN(RESETN), .CMD_VALID(CMD_VALID), .CMD_READY(CMD_READY), .CMD(CMD),
  .BUSY(BUSY), .DONE(DONE), .SCL_HELD(SCL_HELD), .RX_VALID(RX_VALID), .RX_READY(RX_READY),
  .RX_DATA(RX_DATA), .RX_INDEX(RX_INDEX), .SDA_OUT(SDA_OUT), .SCL_OUT(SCL_OUT),
  .SDA_OE(SDA_OE));
`default_nettype wire

// ### bench/i2c_slave_model.sv
// Behavioural bus slave: logs written bytes, serves read bytes 8'h40 upwards.
`default_nettype none
module i2c_slave_model (
  // Wire levels
  input wire logic scl,
  input wire logic sda,
  // Behaviour
  input wire logic nack_en,
  input wire logic stretch_en,
  // Pulls, high = line low
  output logic     sda_pull,
  output logic     scl_pull
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] log_q[$];
  logic [7:0] sh, tx;
  logic       rd, mack;
  int         n_ack, n_nack, cnt, nbyte, ridx;
  initial begin
    sda_pull = 0; scl_pull = 0; rd = 0; mack = 0;
    n_ack = 0; n_nack = 0; cnt = 0; nbyte = 0; ridx = 0; sh = '0; tx = '0;
  end
  // A start resets the byte framing, so a repeated start is taken the same way.
  // The clock fall that closes a start is not a data bit, so counting begins below zero.
  always @(negedge sda) if (scl === 1'b1) begin
    cnt = -1; nbyte = 0; rd = 0; sda_pull = 0;
  end
  always @(posedge sda) if (scl === 1'b1) begin
    cnt = 0; rd = 0; sda_pull = 0;
  end
  always @(posedge scl) begin
    if (cnt < 8 && !rd) sh = {sh[6:0], sda};
    if (cnt == 8 && rd) mack = sda;
  end
  always @(negedge scl) begin
    if (cnt < 8) begin
      cnt++;
      if (cnt == 8) begin
        if (rd) sda_pull = 0;
        else begin
          log_q.push_back(sh);
          sda_pull = !(nack_en && nbyte > 0);
        end
      end else if (rd) sda_pull = !tx[7-cnt];
    end else begin
      cnt = 0;
      sda_pull = 0;
      if (rd && mack) begin
        n_nack++;
        rd = 0;
      end else if (rd) n_ack++;
      if (nbyte == 0 && sh[0]) begin
        rd = 1;
        ridx = 0;
      end
      nbyte++;
      if (rd) begin
        tx = 8'h40 + 8'(ridx);
        ridx++;
        sda_pull = !tx[7];
      end
    end
  end
  // Slow mode holds the clock low after every falling edge.
  always @(negedge scl) if (stretch_en) begin
    scl_pull = 1;
    #500;
    scl_pull = 0;
  end
endmodule
`default_nettype wire

// ### bench/i2c_master_command_engine_tb.sv
// Self-checking testbench for the two-wire command engine.
`default_nettype none
module i2c_master_command_engine_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 0, resetn = 0, cmd_valid = 0, tx_valid = 0, rx_ready = 0;
  logic nack_en = 0, stretch_en = 0, stall = 0;
  i2c_cmd_pkg::cmd_t cmd = '0;
  i2c_cmd_pkg::tx_item_t item = '0;
  logic cmd_ready, tx_ready, rx_valid, rx_last, busy, done, nack_err, scl_held;
  logic sda_out, sda_oe, scl_out, scl_oe, sda_pull, scl_pull, sda_w, scl_w;
  logic [7:0] rx_data;
  logic [8:0] rx_index;
  int fail_count = 0, checks = 0, cyc = 0;
  logic [7:0] exp_q[$];
  logic [15:0] rxd_q[$];
  logic rxl_q[$];
  always #12.5 mclk = ~mclk;
  assign sda_w = ~(sda_oe | sda_pull);
  assign scl_w = ~(scl_oe | scl_pull);
  i2c_master_cmd #(.ARRAY_LEN(8), .QUARTER(4)) DUT (
    .MCLK(mclk), .RESETN(resetn), .CMD_VALID(cmd_valid), .CMD_READY(cmd_ready), .CMD(cmd),
    .TX_VALID(tx_valid), .TX_READY(tx_ready), .TX_ITEM(item), .RX_VALID(rx_valid),
    .RX_READY(rx_ready), .RX_DATA(rx_data), .RX_INDEX(rx_index), .RX_LAST(rx_last),
    .BUSY(busy), .DONE(done), .NACK_ERR(nack_err), .SCL_HELD(scl_held), .SDA_IN(sda_w),
    .SDA_OUT(sda_out), .SDA_OE(sda_oe), .SCL_IN(scl_w), .SCL_OUT(scl_out), .SCL_OE(scl_oe));
  i2c_slave_model slv (.scl(scl_w), .sda(sda_w), .nack_en(nack_en), .stretch_en(stretch_en),
    .sda_pull(sda_pull), .scl_pull(scl_pull));
  always @(negedge mclk) rx_ready = !stall || (cyc % 5 == 0);
  always @(posedge mclk) begin
    cyc++;
    if (rx_valid && rx_ready) begin
      rxd_q.push_back({rx_index[7:0], rx_data});
      rxl_q.push_back(rx_last);
    end
    if (cyc == 90000) begin
      fail_count++;
      close_out();
    end
  end
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic exp_add(input i2c_cmd_pkg::tx_item_t it);
    int k;
    case (it.kind)
      i2c_cmd_pkg::TX_BYTE: exp_q.push_back(it.value[7:0]);
      i2c_cmd_pkg::TX_WORD: exp_q = {exp_q, it.value[15:8], it.value[7:0]};
      i2c_cmd_pkg::TX_REPEAT: for (k = 0; k < it.count; k++) exp_q.push_back(it.value[7:0]);
      i2c_cmd_pkg::TX_DEC: for (k = 4; k >= 0; k--)
        exp_q.push_back(8'h30 + 8'((it.value / (10 ** k)) % 10));
      i2c_cmd_pkg::TX_HEX: for (k = 3; k >= 0; k--)
        exp_q.push_back(it.value[4*k+:4] < 10 ? 8'h30 + it.value[4*k+:4]
                                              : 8'h37 + it.value[4*k+:4]);
      default: for (k = 15; k >= 0; k--) exp_q.push_back(8'h30 + 8'(it.value[k]));
    endcase
  endtask
  task automatic push(input i2c_cmd_pkg::tx_kind_t k, input logic [15:0] v,
                      input logic [7:0] c, input logic l);
    @(negedge mclk);
    tx_valid = 1;
    item = '{k, v, c, l};
    exp_add(item);
    do @(posedge mclk); while (tx_ready !== 1'b1);
  endtask
  task automatic run(input logic r, input logic [7:0] c, input i2c_cmd_pkg::addr_mode_t m,
                     input logic [15:0] a, input i2c_cmd_pkg::rx_kind_t k, input logic u,
                     input logic [7:0] n);
    int w;
    @(negedge mclk);
    cmd = '{r, c, m, a, k, u, n};
    cmd_valid = 1;
    do @(posedge mclk); while (cmd_ready !== 1'b1);
    @(negedge mclk);
    cmd_valid = 0;
    for (w = 0; w < 60000 && done !== 1'b1; w++) @(negedge mclk);
    check(done, 1);
    repeat (2) @(negedge mclk);
  endtask
  task automatic cmp_log(input int b);
    check(16'(slv.log_q.size() - b), 16'(exp_q.size()));
    foreach (exp_q[i]) check(16'(slv.log_q[b+i]), 16'(exp_q[i]));
  endtask
  task automatic sc_write;
    int b;
    b = slv.log_q.size();
    exp_q = {8'ha0, 8'h12, 8'h34};
    stretch_en = 1;
    fork
      run(0, 8'ha1, i2c_cmd_pkg::ADDR_16, 16'h1234, i2c_cmd_pkg::RX_BYTES, 0, 0);
      begin
        push(i2c_cmd_pkg::TX_BYTE, 16'h005c, 0, 0);
        push(i2c_cmd_pkg::TX_WORD, 16'hbeef, 0, 0);
        push(i2c_cmd_pkg::TX_REPEAT, 16'h002a, 2, 0);
        push(i2c_cmd_pkg::TX_DEC, 16'd1234, 0, 0);
        push(i2c_cmd_pkg::TX_HEX, 16'h0abc, 0, 0);
        push(i2c_cmd_pkg::TX_BIN, 16'h8001, 0, 1);
        @(negedge mclk) tx_valid = 0;
      end
    join
    stretch_en = 0;
    cmp_log(b);
    check(scl_held, 1);
    check(sda_oe, 0);
  endtask
  task automatic sc_buffer;
    int b;
    b = slv.log_q.size();
    exp_q = {8'ha0};
    push(i2c_cmd_pkg::TX_BYTE, 16'h0001, 0, 0);
    push(i2c_cmd_pkg::TX_BYTE, 16'h0002, 0, 1);
    @(negedge mclk);
    item = '{i2c_cmd_pkg::TX_BYTE, 16'h0077, 8'h00, 1'b1};
    repeat (4) @(negedge mclk);
    check(tx_ready, 0);
    check(16'(slv.log_q.size() - b), 0);
    tx_valid = 0;
    run(0, 8'ha0, i2c_cmd_pkg::ADDR_NONE, 0, i2c_cmd_pkg::RX_BYTES, 0, 0);
    cmp_log(b);
  endtask
  task automatic sc_nack;
    nack_en = 1;
    push(i2c_cmd_pkg::TX_BYTE, 16'h0011, 0, 1);
    @(negedge mclk) tx_valid = 0;
    run(0, 8'ha0, i2c_cmd_pkg::ADDR_NONE, 0, i2c_cmd_pkg::RX_BYTES, 0, 0);
    check(nack_err, 1);
    nack_en = 0;
  endtask
  task automatic sc_read_addr;
    int b, a, na;
    b = slv.log_q.size();
    a = slv.n_ack;
    na = slv.n_nack;
    rxd_q.delete();
    rxl_q.delete();
    stall = 1;
    run(1, 8'ha0, i2c_cmd_pkg::ADDR_8, 16'h0055, i2c_cmd_pkg::RX_BYTES, 0, 3);
    stall = 0;
    exp_q = {8'ha0, 8'h55, 8'ha1};
    cmp_log(b);
    check(16'(rxd_q.size()), 3);
    foreach (rxd_q[i]) check(rxd_q[i], {8'(i), 8'h40 + 8'(i)});
    check(rxl_q[2], 1);
    check(16'(slv.n_ack - a), 2);
    check(16'(slv.n_nack - na), 1);
    check(nack_err, 0);
    check({scl_held, sda_oe, scl_oe}, 0);
  endtask
  task automatic sc_reads;
    int n, b;
    for (int i = 0; i < 3; i++) begin
      b = slv.log_q.size();
      rxd_q.delete();
      n = (i == 0) ? 4 : (i == 1) ? 3 : 8;
      run(1, 8'ha1, i2c_cmd_pkg::ADDR_NONE, 0,
          (i == 0) ? i2c_cmd_pkg::RX_WORDS : i2c_cmd_pkg::RX_ARRAY, i == 1, (i == 2) ? 5 : 2 + i);
      exp_q = {8'ha1};
      cmp_log(b);
      check(16'(rxd_q.size()), 16'(n));
      check(rxd_q[n-1], {8'(n - 1), 8'h40 + 8'(n - 1)});
    end
  endtask
  initial begin
    repeat (16) @(negedge mclk);
    resetn = 1;
    sc_write();
    sc_buffer();
    sc_nack();
    sc_read_addr();
    sc_reads();
    close_out();
  end
endmodule
`default_nettype wire
